// ==== common/rpt_pkg.sv ====
package rpt_pkg;

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_CONTROL_A     = 8'h00;
    localparam logic [7:0] OFS_STATUS        = 8'h04;
    localparam logic [7:0] OFS_INT_ENABLE    = 8'h08;
    localparam logic [7:0] OFS_INT_FLAGS     = 8'h0C;
    localparam logic [7:0] OFS_COUNTER_VALUE = 8'h10;
    localparam logic [7:0] OFS_PERIOD_VALUE  = 8'h14;
    localparam logic [7:0] OFS_COMPARE_VALUE = 8'h18;
    localparam logic [7:0] OFS_CLOCK_SELECT  = 8'h1C;
    localparam logic [7:0] OFS_PIT_CONTROL   = 8'h20;
    localparam logic [7:0] OFS_PIT_STATUS    = 8'h24;
    localparam logic [7:0] OFS_PIT_INT_EN    = 8'h28;
    localparam logic [7:0] OFS_PIT_INT_FLAGS = 8'h2C;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int CTRL_EN_BIT     = 0;
    localparam int CTRL_PRESC_LSB  = 3;
    localparam int SEL_W           = 4;
    localparam int IRQ_OVF_BIT     = 0;
    localparam int IRQ_CMP_BIT     = 1;
    localparam int BUSY_CONTROL_A_BIT  = 0;
    localparam int BUSY_CNT_BIT    = 1;
    localparam int BUSY_PER_BIT    = 2;
    localparam int BUSY_CMP_BIT    = 3;
    localparam int PIT_EN_BIT      = 0;
    localparam int PIT_PERIOD_LSB  = 1;
    localparam int CNT_W           = 16;

    // ************************************************************
    // Reset values and timing counts
    // ************************************************************
    localparam logic [15:0] PERIOD_RESET  = 16'hFFFF;
    localparam logic [15:0] COMPARE_RESET = 16'h0000;
    localparam logic [3:0]  PIT_SEL_MAX   = 4'hE;
    localparam logic [4:0]  ULP_DIV_LAST  = 5'h1F;
    localparam int          PIT_EVT_LSB   = 5;
    localparam int          PIT_EVT_NUM   = 8;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        RPT_SRC_XTAL,
        RPT_SRC_EXT,
        RPT_SRC_ULP,
        RPT_SRC_ULP_DIV32
    } rpt_src_t;

    typedef struct packed {
        logic                   overflow;
        logic                   compare;
        logic [PIT_EVT_NUM-1:0] pit_level;
    } rpt_evt_t;

endpackage

// ==== hw/rpt_core.sv ====
`timescale 1ns/100ps

module rpt_core #(
    parameter int PRESC_W = 15
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic              hready,
    input  wire logic [31:0]       hwdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic [31:0]            hrdata,
    // Kernel clock sources, asynchronous
    input  wire logic              xtal_clk,
    input  wire logic              ext_clk,
    input  wire logic              ultra_low_power_osc,
    // Interrupts and events
    output logic                   irq_counter,
    output logic                   irq_periodic,
    output rpt_pkg::rpt_evt_t      events
);

    // ************************************************************
    // Helpers
    // ************************************************************
    function automatic logic [PRESC_W-1:0] low_ones(input logic [3:0] n);
        logic [PRESC_W-1:0] m;
        m = '0;
        for (int i = 0; i < PRESC_W; i++) begin
            if (i < int'(n)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        return (a[31:8] == 24'h000000) && (a[7:0] == ofs);
    endfunction

    // ************************************************************
    // State
    // ************************************************************
    logic [2:0]                   src_s1;
    logic [2:0]                   src_s2;
    logic [2:0]                   src_s3;
    logic [2:0]                   src_edge;
    logic [4:0]                   ulp_div_cnt;
    logic                         kernel_tick;
    rpt_pkg::rpt_src_t            src_sel;
    logic [PRESC_W-1:0]           presc;
    logic                         presc_run;
    logic                         cnt_tick;
    logic                         pit_tick;
    logic                         ctrl_en;
    logic [3:0]                   presc_sel;
    logic [15:0]                  cnt;
    logic [15:0]                  period_value;
    logic [15:0]                  cmp;
    logic                         ovf_en;
    logic                         cmp_en;
    logic                         ovf_flag;
    logic                         cmp_flag;
    logic [3:0]                   busy;
    logic                         pit_en;
    logic [3:0]                   pit_sel;
    logic                         pit_ie;
    logic                         pit_flag;
    logic                         pit_busy;
    logic                         wr_pend;
    logic [31:0]                  wr_addr;
    logic [31:0]                  rd_data;
    logic                         acc;
    logic                         wr_ctrl;
    logic                         wr_cnt;
    logic                         wr_per;
    logic                         wr_cmp;
    logic                         wr_pit;
    logic                         ovf_hit;
    logic                         cmp_hit;

    // ************************************************************
    // Kernel clock selection
    // ************************************************************
    // Edges are taken from the second stage, so must hold for no tick to be lost.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            src_s1 <= 3'h0;
            src_s2 <= 3'h0;
            src_s3 <= 3'h0;
        end else begin
            src_s1 <= {ultra_low_power_osc, ext_clk, xtal_clk};
            src_s2 <= src_s1;
            src_s3 <= src_s2;
        end
    end

    assign src_edge = src_s2 & ~src_s3;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ulp_div_cnt <= 5'h00;
        end else if (src_edge[2]) begin
            ulp_div_cnt <= ulp_div_cnt + 5'h01;
        end
    end

    always_comb begin
        case (src_sel)
            rpt_pkg::RPT_SRC_XTAL:  kernel_tick = src_edge[0];
            rpt_pkg::RPT_SRC_EXT:   kernel_tick = src_edge[1];
            rpt_pkg::RPT_SRC_ULP:   kernel_tick = src_edge[2];
            default:                kernel_tick = src_edge[2] &&
                                                  (ulp_div_cnt == rpt_pkg::ULP_DIV_LAST);
        endcase
    end

    // ************************************************************
    // Shared prescaler and ticks
    // ************************************************************
    assign presc_run = ctrl_en | pit_en;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            presc <= '0;
        end else if (!presc_run) begin
            presc <= '0;
        end else if (kernel_tick) begin
            presc <= presc + 1'b1;
        end
    end

    assign cnt_tick = ctrl_en && kernel_tick &&
                      ((presc & low_ones(presc_sel)) == low_ones(presc_sel));
    assign pit_tick = pit_en && (pit_sel != 4'h0) && (pit_sel <= rpt_pkg::PIT_SEL_MAX) &&
                      kernel_tick &&
                      ((presc & low_ones(pit_sel + 4'h1)) == low_ones(pit_sel + 4'h1));
    assign ovf_hit  = cnt_tick && (cnt == period_value);
    assign cmp_hit  = cnt_tick && (cnt == cmp);

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    assign acc     = hsel && htrans[1] && hready;
    assign wr_ctrl = wr_pend && hit(wr_addr, rpt_pkg::OFS_CONTROL_A);
    assign wr_cnt  = wr_pend && hit(wr_addr, rpt_pkg::OFS_COUNTER_VALUE);
    assign wr_per  = wr_pend && hit(wr_addr, rpt_pkg::OFS_PERIOD_VALUE);
    assign wr_cmp  = wr_pend && hit(wr_addr, rpt_pkg::OFS_COMPARE_VALUE);
    assign wr_pit  = wr_pend && hit(wr_addr, rpt_pkg::OFS_PIT_CONTROL);

    always_comb begin
        rd_data = 32'h00000000;
        if (hit(haddr, rpt_pkg::OFS_CONTROL_A)) begin
            rd_data[rpt_pkg::CTRL_EN_BIT] = ctrl_en;
            rd_data[rpt_pkg::CTRL_PRESC_LSB +: rpt_pkg::SEL_W] = presc_sel;
        end else if (hit(haddr, rpt_pkg::OFS_STATUS)) begin
            rd_data[3:0] = busy;
        end else if (hit(haddr, rpt_pkg::OFS_INT_ENABLE)) begin
            rd_data[rpt_pkg::IRQ_OVF_BIT] = ovf_en;
            rd_data[rpt_pkg::IRQ_CMP_BIT] = cmp_en;
        end else if (hit(haddr, rpt_pkg::OFS_INT_FLAGS)) begin
            rd_data[rpt_pkg::IRQ_OVF_BIT] = ovf_flag;
            rd_data[rpt_pkg::IRQ_CMP_BIT] = cmp_flag;
        end else if (hit(haddr, rpt_pkg::OFS_COUNTER_VALUE)) begin
            rd_data[15:0] = cnt;
        end else if (hit(haddr, rpt_pkg::OFS_PERIOD_VALUE)) begin
            rd_data[15:0] = period_value;
        end else if (hit(haddr, rpt_pkg::OFS_COMPARE_VALUE)) begin
            rd_data[15:0] = cmp;
        end else if (hit(haddr, rpt_pkg::OFS_CLOCK_SELECT)) begin
            rd_data[1:0] = src_sel;
        end else if (hit(haddr, rpt_pkg::OFS_PIT_CONTROL)) begin
            rd_data[rpt_pkg::PIT_EN_BIT] = pit_en;
            rd_data[rpt_pkg::PIT_PERIOD_LSB +: rpt_pkg::SEL_W] = pit_sel;
        end else if (hit(haddr, rpt_pkg::OFS_PIT_STATUS)) begin
            rd_data[0] = pit_busy;
        end else if (hit(haddr, rpt_pkg::OFS_PIT_INT_EN)) begin
            rd_data[0] = pit_ie;
        end else if (hit(haddr, rpt_pkg::OFS_PIT_INT_FLAGS)) begin
            rd_data[0] = pit_flag;
        end
    end

    // Zero wait states: read data is fetched in the address phase for the next cycle.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            hrdata    <= 32'h00000000;
            wr_pend   <= 1'b0;
            wr_addr   <= 32'h00000000;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend   <= acc && hwrite;
            if (acc) begin
                wr_addr <= haddr;
            end
            if (acc && !hwrite) begin
                hrdata <= rd_data;
            end
        end
    end

    // ************************************************************
    // Configuration registers
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_en   <= 1'b0;
            presc_sel <= 4'h0;
            ovf_en    <= 1'b0;
            cmp_en    <= 1'b0;
            period_value       <= rpt_pkg::PERIOD_RESET;
            cmp       <= rpt_pkg::COMPARE_RESET;
            src_sel   <= rpt_pkg::RPT_SRC_XTAL;
            pit_en    <= 1'b0;
            pit_sel   <= 4'h0;
            pit_ie    <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_en   <= hwdata[rpt_pkg::CTRL_EN_BIT];
                presc_sel <= hwdata[rpt_pkg::CTRL_PRESC_LSB +: rpt_pkg::SEL_W];
            end
            if (wr_pend && hit(wr_addr, rpt_pkg::OFS_INT_ENABLE)) begin
                ovf_en <= hwdata[rpt_pkg::IRQ_OVF_BIT];
                cmp_en <= hwdata[rpt_pkg::IRQ_CMP_BIT];
            end
            if (wr_per) begin
                period_value <= hwdata[15:0];
            end
            if (wr_cmp) begin
                cmp <= hwdata[15:0];
            end
            if (wr_pend && hit(wr_addr, rpt_pkg::OFS_CLOCK_SELECT)) begin
                src_sel <= rpt_pkg::rpt_src_t'(hwdata[1:0]);
            end
            if (wr_pit) begin
                pit_en  <= hwdata[rpt_pkg::PIT_EN_BIT];
                pit_sel <= hwdata[rpt_pkg::PIT_PERIOD_LSB +: rpt_pkg::SEL_W];
            end
            if (wr_pend && hit(wr_addr, rpt_pkg::OFS_PIT_INT_EN)) begin
                pit_ie <= hwdata[0];
            end
        end
    end

    // Busy bits mark a write not yet seen by a kernel edge; a new write wins over the clear.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            busy     <= 4'h0;
            pit_busy <= 1'b0;
        end else begin
            busy     <= (kernel_tick ? 4'h0 : busy) | {wr_cmp, wr_per, wr_cnt, wr_ctrl};
            pit_busy <= (pit_busy && !kernel_tick) || wr_pit;
        end
    end

    // ************************************************************
    // Counter, flags and events
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt <= 16'h0000;
        end else if (wr_cnt) begin
            cnt <= hwdata[15:0];
        end else if (ovf_hit) begin
            cnt <= 16'h0000;
        end else if (cnt_tick) begin
            cnt <= cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_flag <= 1'b0;
            cmp_flag <= 1'b0;
            pit_flag <= 1'b0;
        end else begin
            if (ovf_hit) begin
                ovf_flag <= 1'b1;
            end else if (wr_pend && hit(wr_addr, rpt_pkg::OFS_INT_FLAGS) &&
                         hwdata[rpt_pkg::IRQ_OVF_BIT]) begin
                ovf_flag <= 1'b0;
            end
            if (cmp_hit) begin
                cmp_flag <= 1'b1;
            end else if (wr_pend && hit(wr_addr, rpt_pkg::OFS_INT_FLAGS) &&
                         hwdata[rpt_pkg::IRQ_CMP_BIT]) begin
                cmp_flag <= 1'b0;
            end
            if (pit_tick) begin
                pit_flag <= 1'b1;
            end else if (wr_pend && hit(wr_addr, rpt_pkg::OFS_PIT_INT_FLAGS) && hwdata[0]) begin
                pit_flag <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            irq_counter  <= 1'b0;
            irq_periodic <= 1'b0;
        end else begin
            irq_counter  <= (ovf_flag && ovf_en) || (cmp_flag && cmp_en);
            irq_periodic <= pit_flag && pit_ie;
        end
    end

    // Pulse events last one kernel period: set on the hit, dropped on the next kernel edge.
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            events <= '0;
        end else begin
            if (ovf_hit) begin
                events.overflow <= 1'b1;
            end else if (kernel_tick) begin
                events.overflow <= 1'b0;
            end
            if (cmp_hit) begin
                events.compare <= 1'b1;
            end else if (kernel_tick) begin
                events.compare <= 1'b0;
            end
            events.pit_level <= pit_en ?
                presc[rpt_pkg::PIT_EVT_LSB +: rpt_pkg::PIT_EVT_NUM] : '0;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_ovf_hit;
        ovf_hit && !wr_cnt;
    endsequence

    sequence s_pit_raise;
        pit_tick && pit_ie;
    endsequence

    property p_cmp_flag;
        @(posedge clk_sys) disable iff (sys_rst) cmp_hit |=> cmp_flag && events.compare;
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missed");

    property p_ovf_wrap;
        @(posedge clk_sys) disable iff (sys_rst) s_ovf_hit |=> (cnt == 16'h0000) && ovf_flag;
    endproperty
    a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow did not wrap");

    property p_ovf_event;
        @(posedge clk_sys) disable iff (sys_rst) s_ovf_hit |=> events.overflow;
    endproperty
    a_ovf_event: assert property (p_ovf_event) else $error("overflow event missed");

    property p_cnt_inc;
        @(posedge clk_sys) disable iff (sys_rst)
            cnt_tick && (cnt != period_value) && !wr_cnt |=> cnt == $past(cnt) + 16'h0001;
    endproperty
    a_cnt_inc: assert property (p_cnt_inc) else $error("counter did not step");

    property p_stop;
        @(posedge clk_sys) disable iff (sys_rst) !ctrl_en && !wr_cnt |=> $stable(cnt);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_presc_off;
        @(posedge clk_sys) disable iff (sys_rst) !ctrl_en && !pit_en |=> presc == '0;
    endproperty
    a_presc_off: assert property (p_presc_off) else $error("prescaler ran while idle");

    property p_irq_hold;
        @(posedge clk_sys) disable iff (sys_rst)
            (cmp_flag && cmp_en) [*2] |-> irq_counter;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("counter irq dropped");

    property p_pit_irq;
        @(posedge clk_sys) disable iff (sys_rst) s_pit_raise |=> pit_flag ##1 irq_periodic;
    endproperty
    a_pit_irq: assert property (p_pit_irq) else $error("periodic irq missed");

    property p_pit_level;
        @(posedge clk_sys) disable iff (sys_rst)
            pit_en |=> events.pit_level ==
                $past(presc[rpt_pkg::PIT_EVT_LSB +: rpt_pkg::PIT_EVT_NUM]);
    endproperty
    a_pit_level: assert property (p_pit_level) else $error("periodic level wrong");

    property p_div1;
        @(posedge clk_sys) disable iff (sys_rst)
            ctrl_en && (presc_sel == 4'h0) && kernel_tick |-> cnt_tick;
    endproperty
    a_div1: assert property (p_div1) else $error("undivided tick missed");

    property p_rd_ctrl;
        @(posedge clk_sys) disable iff (sys_rst)
            acc && !hwrite && hit(haddr, rpt_pkg::OFS_CONTROL_A) |=> hrdata[0] == $past(ctrl_en);
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("enable readback wrong");

endmodule // rpt_core

// ==== sim/rpt_core_test.sv ====
`timescale 1ns/100ps

module rpt_core_test;
    // ************************************************************
    // Signals
    // ************************************************************
    logic              clk_sys  = 1'b0;
    logic              sys_rst  = 1'b1;
    logic              hsel     = 1'b0;
    logic [31:0]       haddr    = 32'h0;
    logic [1:0]        htrans   = 2'h0;
    logic              hwrite   = 1'b0;
    logic [2:0]        hsize    = 3'h2;
    logic [31:0]       hwdata   = 32'h0;
    wire logic         hready;
    logic              hreadyout, hresp, irq_counter, irq_periodic;
    logic [31:0]       hrdata, rd, rd2;
    logic              xtal_clk = 1'b0;
    logic              ext_clk  = 1'b0;
    logic              ultra_low_power_osc = 1'b0;
    rpt_pkg::rpt_evt_t events;
    int                n_errors = 0;
    int                n_checks = 0;
    integer            seed = 32'hb394;
    int                xe = 0, ee = 0, ue = 0, src, t0, t1, p_val, c_val, n, div;

    // One slave only, so its ready is the bus ready.
    assign hready = hreadyout;

    rpt_core #(.PRESC_W(15)) i_dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
        .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .xtal_clk(xtal_clk), .ext_clk(ext_clk), .ultra_low_power_osc(ultra_low_power_osc),
        .irq_counter(irq_counter), .irq_periodic(irq_periodic), .events(events));

    // ************************************************************
    // Clocks, kept well below a quarter of the system clock
    // ************************************************************
    always #25 clk_sys = ~clk_sys;
    initial begin #3; forever #200 xtal_clk = ~xtal_clk; end
    initial begin #7; forever #250 ext_clk = ~ext_clk; end
    initial begin #13; forever #175 ultra_low_power_osc = ~ultra_low_power_osc; end
    always @(posedge xtal_clk) xe++;
    always @(posedge ext_clk) ee++;
    always @(posedge ultra_low_power_osc) ue++;

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] q);
        @(posedge clk_sys);
        hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr;
        do @(posedge clk_sys); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge clk_sys); while (hready !== 1'b1);
        q = hrdata;
    endtask

    // Both busy registers are polled before every write, the first one included.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        do bus(1'b0, rpt_pkg::OFS_STATUS, 32'h0, q); while (q !== 32'h0);
        do bus(1'b0, rpt_pkg::OFS_PIT_STATUS, 32'h0, q); while (q !== 32'h0);
        bus(1'b1, a, d, q);
    endtask

    function automatic logic pick(input int w);
        case (w)
            0: pick = events.overflow;
            1: pick = events.compare;
            2: pick = events.pit_level[0];
            default: pick = irq_periodic;
        endcase
    endfunction

    // Rising edge of a watched output, stamped with edges of the selected source.
    task automatic wait_rise(input int w, output int stamp);
        int k;
        logic prev, cur;
        prev = pick(w);
        k = 0;
        forever begin
            @(negedge clk_sys);
            cur = pick(w);
            if ((cur === 1'b1 && prev === 1'b0) || k > 40000) break;
            prev = cur;
            k++;
        end
        if (k > 40000) check(1'b0, 1'b1);
        stamp = (src == 0) ? xe : (src == 1) ? ee : ue;
    endtask

    task automatic wrap_up;
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_sys);
        n_errors++;
        wrap_up();
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        src = 0;
        bus(1'b0, rpt_pkg::OFS_PERIOD_VALUE, 32'h0, rd);  check(rd, 32'h0000FFFF);
        bus(1'b0, rpt_pkg::OFS_COMPARE_VALUE, 32'h0, rd); check(rd, 32'h0);
        bus(1'b0, rpt_pkg::OFS_CONTROL_A, 32'h0, rd);     check(rd, 32'h0);
        bus(1'b0, 8'h30, 32'h0, rd);                      check(rd, 32'h0);
        check(hresp, 1'b0);
        check(hreadyout, 1'b1);
        check(events.pit_level, 8'h00);
        for (src = 0; src < 4; src++) begin
            // Random period from the seed; the bench model derives every interval.
            p_val = 3 + ($random(seed) & 7);
            c_val = p_val / 2;
            n = (src == 1) ? 2 : 0;
            div = ((src == 3) ? 32 : 1) << n;
            wr(rpt_pkg::OFS_CLOCK_SELECT, src);
            wr(rpt_pkg::OFS_PERIOD_VALUE, p_val);
            wr(rpt_pkg::OFS_COMPARE_VALUE, c_val);
            wr(rpt_pkg::OFS_INT_ENABLE, (src == 2) ? 32'h1 : 32'h3);
            // A count held from the last pass may exceed the new period and take a full wrap.
            wr(rpt_pkg::OFS_COUNTER_VALUE, 32'h0);
            wr(rpt_pkg::OFS_CONTROL_A, (n << 3) | 1);
            wait_rise(0, t0);
            // Flags have no busy bit, so the clear goes out at once, ahead of the compare.
            bus(1'b1, rpt_pkg::OFS_INT_FLAGS, 32'h3, rd);
            wait_rise(1, t1);
            check(t1 - t0, (c_val + 1) * div);
            repeat (3) @(negedge clk_sys);
            check(irq_counter, (src == 2) ? 1'b0 : 1'b1);
            wait_rise(0, t1);
            check(t1 - t0, (p_val + 1) * div);
            repeat (3) @(negedge clk_sys);
            check(irq_counter, 1'b1);
            bus(1'b0, rpt_pkg::OFS_INT_FLAGS, 32'h0, rd);
            check(rd, 32'h3);
            bus(1'b0, rpt_pkg::OFS_COUNTER_VALUE, 32'h0, rd);
            check(rd <= p_val, 1'b1);
            wr(rpt_pkg::OFS_CONTROL_A, 32'h0);
            bus(1'b0, rpt_pkg::OFS_COUNTER_VALUE, 32'h0, rd);
            repeat (300) @(negedge clk_sys);
            bus(1'b0, rpt_pkg::OFS_COUNTER_VALUE, 32'h0, rd2);
            check(rd2, rd);
            wr(rpt_pkg::OFS_INT_FLAGS, 32'h3);
            repeat (3) @(negedge clk_sys);
            check(irq_counter, 1'b0);
        end
        // Periodic timer alone, counter left disabled.
        src = 0;
        wr(rpt_pkg::OFS_CLOCK_SELECT, 32'h0);
        wr(rpt_pkg::OFS_PIT_INT_EN, 32'h1);
        for (n = 1; n < 4; n += 2) begin
            wr(rpt_pkg::OFS_PIT_CONTROL, (n << 1) | 1);
            wr(rpt_pkg::OFS_PIT_INT_FLAGS, 32'h1);
            wait_rise(3, t0);
            wr(rpt_pkg::OFS_PIT_INT_FLAGS, 32'h1);
            wait_rise(3, t1);
            check(t1 - t0, 1 << (n + 1));
        end
        wait_rise(2, t0);
        wait_rise(2, t1);
        check(t1 - t0, 64);
        wr(rpt_pkg::OFS_PIT_CONTROL, 32'h0);
        repeat (10) @(negedge clk_sys);
        check(events.pit_level, 8'h00);
        wrap_up();
    end
endmodule // rpt_core_test
